//--- design/rsp_map.vh
// constants for the reset strap and pin function block
`ifndef RSP_MAP_VH
`define RSP_MAP_VH
`define RSP_RST_MIN_NS 1000
`define RSP_CLK_NS 100
`define RSP_MODE_SPI 2'h3
`define RSP_I2C_ADDR_BASE 7'h74
`define RSP_REF_XTAL 2'h1
`define RSP_REF_EXT 2'h2
`define RSP_ST_RESET 3'h1
`define RSP_ST_CAPTURE 3'h2
`define RSP_ST_RUN 3'h4
`define RSP_CFG_DEFAULT 3'h0
`define RSP_STATUS_W 6
`endif

//--- design/rsp_reset_strap.v
// reset, strap capture and shared pin function logic
// Summary of operation
// - reset low forces the strap registers and pin enables to default and holds the device in reset
// - sample the three autoconfig pins on reset release to pick configuration
// - after reset the factory strap pin outputs pll lock, 1 means locked
// - sample both interface mode straps on reset release
// - in spi mode drive read data on the readout pin during reads
// - every host pin output can be released to high impedance
// - ref select 01 enables crystal driver, 10 accepts external clock
// - mode 00,01,10 select i2c addresses 0x74..0x76, 11 selects spi
// - latch sampled straps into a readable status register on release
`timescale 1ns/1ps
`include "rsp_map.vh"
module rsp_reset_strap
#(
  parameter CFG_W = 3,
  parameter MODE_W = 2,
  parameter ADDR_W = 7,
  parameter STATUS_W = `RSP_STATUS_W
)
(
  input wire clk,
  input wire sys_rst,
  input wire device_reset_low,
  input wire autoconfig_sel_bit0,
  input wire autoconfig_sel_bit1,
  input wire autoconfig_sel_bit2,
  input wire factory_strap_lock_pin_in,
  output reg factory_strap_lock_pin_out,
  output reg factory_strap_lock_pin_oe,
  input wire ifmode0_chipsel_pin_in,
  input wire ifmode1_readout_pin_in,
  output reg ifmode1_readout_pin_out,
  output reg ifmode1_readout_pin_oe,
  input wire sda_out_req,
  input wire sda_oe_req,
  output reg sda_pin_out,
  output reg sda_pin_oe,
  input wire spi_read_active,
  input wire spi_read_data,
  input wire pll_lock_indicator,
  input wire [1:0] ref_source_select,
  output reg xtal_driver_en,
  output reg ext_clk_en,
  output reg core_reset_q,
  output reg [CFG_W-1:0] config_sel_q,
  output reg spi_mode_q,
  output reg [ADDR_W-1:0] i2c_addr_q,
  output reg [STATUS_W-1:0] strap_capture_status_q,
  output reg serial_chip_select_low
);
  // one-hot states; any stray code falls back to reset
  localparam [2:0] ST_RESET = `RSP_ST_RESET;
  localparam [2:0] ST_CAPTURE = `RSP_ST_CAPTURE;
  localparam [2:0] ST_RUN = `RSP_ST_RUN;
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg rst_sync1_q;
  reg rst_sync2_q;
  wire [MODE_W-1:0] mode_w;
  wire [CFG_W-1:0] ac_w;
  // next-state qualifiers for the pin processes, current-state capture/hold for the strap registers
  wire run_next_w;
  wire spi_run_w;
  wire i2c_run_w;
  wire capture_w;
  wire hold_w;
  assign mode_w = {ifmode1_readout_pin_in, ifmode0_chipsel_pin_in};
  assign ac_w = {autoconfig_sel_bit2, autoconfig_sel_bit1, autoconfig_sel_bit0};
  assign run_next_w = (state_d == ST_RUN);
  assign spi_run_w = run_next_w && spi_mode_q;
  assign i2c_run_w = run_next_w && !spi_mode_q;
  assign capture_w = (state_q == ST_RESET) && rst_sync2_q;
  assign hold_w = (state_q == ST_RESET) && !rst_sync2_q;
  // reset pin is async; two flops before it steers anything
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      rst_sync1_q <= 1'b0;
      rst_sync2_q <= 1'b0;
    end
    else
    begin
      rst_sync1_q <= device_reset_low;
      rst_sync2_q <= rst_sync1_q;
    end
  end
  always @*
  begin
    state_d = state_q;
    case (state_q)
      ST_RESET:
      begin
        if (rst_sync2_q)
        begin
          state_d = ST_CAPTURE;
        end
      end
      // capture is its own state: pins keep strap roles one more cycle
      ST_CAPTURE:
      begin
        state_d = ST_RUN;
      end
      ST_RUN:
      begin
        if (!rst_sync2_q)
        begin
          state_d = ST_RESET;
        end
      end
      default:
      begin
        state_d = ST_RESET;
      end
    endcase
  end
  // core reset follows the next state so it drops together with the oe's
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_q <= ST_RESET;
      core_reset_q <= 1'b1;
    end
    else
    begin
      state_q <= state_d;
      core_reset_q <= !run_next_w;
    end
  end
  // straps skip the synchroniser: they are static around release
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      config_sel_q <= `RSP_CFG_DEFAULT;
      spi_mode_q <= 1'b0;
      i2c_addr_q <= `RSP_I2C_ADDR_BASE;
      strap_capture_status_q <= {STATUS_W{1'b0}};
    end
    else if (hold_w)
    begin
      // defaults while held in reset
      config_sel_q <= `RSP_CFG_DEFAULT;
      spi_mode_q <= 1'b0;
      i2c_addr_q <= `RSP_I2C_ADDR_BASE;
      strap_capture_status_q <= {STATUS_W{1'b0}};
    end
    else if (capture_w)
    begin
      // one-shot capture; pins are still straps here
      config_sel_q <= ac_w;
      spi_mode_q <= (mode_w == `RSP_MODE_SPI);
      i2c_addr_q <= `RSP_I2C_ADDR_BASE + {5'h00, mode_w};
      strap_capture_status_q <= {factory_strap_lock_pin_in, mode_w, ac_w};
    end
  end
  // lock pin stays released until run so the test strap reads clean
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      factory_strap_lock_pin_out <= 1'b0;
      factory_strap_lock_pin_oe <= 1'b0;
    end
    else
    begin
      factory_strap_lock_pin_out <= pll_lock_indicator;
      factory_strap_lock_pin_oe <= run_next_w;
    end
  end
  // readout only driven while selected, so the strap pull wins in reset
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      serial_chip_select_low <= 1'b1;
      ifmode1_readout_pin_out <= 1'b0;
      ifmode1_readout_pin_oe <= 1'b0;
    end
    else
    begin
      // chip select only honoured in spi mode
      serial_chip_select_low <= !spi_run_w | ifmode0_chipsel_pin_in;
      ifmode1_readout_pin_out <= spi_read_data;
      ifmode1_readout_pin_oe <= spi_run_w && spi_read_active
        && !ifmode0_chipsel_pin_in;
    end
  end
  // sda is open drain: it only ever pulls low
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      sda_pin_out <= 1'b0;
      sda_pin_oe <= 1'b0;
    end
    else
    begin
      sda_pin_out <= 1'b0;
      sda_pin_oe <= i2c_run_w && sda_oe_req && !sda_out_req;
    end
  end
  // reference source decode; other codes leave both off
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      xtal_driver_en <= 1'b0;
      ext_clk_en <= 1'b0;
    end
    else
    begin
      xtal_driver_en <= (ref_source_select == `RSP_REF_XTAL);
      ext_clk_en <= (ref_source_select == `RSP_REF_EXT);
    end
  end
endmodule // rsp_reset_strap

//--- testbench/rsp_host_model.sv
// far-side serial master driving the shared strap pins
`timescale 1ns/1ps
module rsp_host_model
(
  input wire clk,
  input wire in_reset,
  input wire [1:0] mode,
  input wire want,
  output reg cs_pin = 1'h1,
  output reg miso_pin = 1'h0
);
  // straps hold through the capture edge, then the pins take run roles
  // serial clock and mosi belong to the host and the spi core
  always @(posedge clk)
  begin
    cs_pin <= #1 in_reset ? mode[0] : !want;
    miso_pin <= #1 in_reset ? mode[1] : !miso_pin; // released line toggles
  end
endmodule // rsp_host_model

//--- testbench/rsp_reset_strap_props.sv
// port assertions for the reset strap block
`timescale 1ns/1ps
module rsp_reset_strap_props
(
  input wire clk,
  input wire sys_rst,
  input wire device_reset_low,
  input wire core_reset_q,
  input wire [2:0] config_sel_q,
  input wire [5:0] strap_capture_status_q,
  input wire spi_mode_q,
  input wire pll_lock_indicator,
  input wire factory_strap_lock_pin_out,
  input wire factory_strap_lock_pin_oe,
  input wire ifmode1_readout_pin_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // two cycles, so $past never looks back into reset
  sequence run2; !core_reset_q [*2]; endsequence
  sequence held2; core_reset_q [*2]; endsequence
  hold_low_a: assert property (!device_reset_low [*4] |-> core_reset_q)
    else $error("device not held in reset");
  held_quiet_a: assert property (held2 |-> !factory_strap_lock_pin_oe)
    else $error("lock pin driven in reset");
  lock_out_a: assert property (run2 |-> factory_strap_lock_pin_oe &&
    factory_strap_lock_pin_out == $past(pll_lock_indicator)) else $error("lock out");
  cfg_keep_a: assert property (run2 |-> $stable(strap_capture_status_q))
    else $error("straps resampled");
  status_cfg_a: assert property (!core_reset_q |->
    strap_capture_status_q[2:0] == config_sel_q) else $error("config differs");
  spi_dec_a: assert property (!core_reset_q |-> spi_mode_q == &strap_capture_status_q[4:3])
    else $error("mode decode");
  miso_gate_a: assert property (ifmode1_readout_pin_oe |-> spi_mode_q)
    else $error("miso driven in i2c");
  late_run_a: assert property ($fell(core_reset_q) |-> $past(device_reset_low, 2))
    else $error("run before release");
endmodule // rsp_reset_strap_props
bind rsp_reset_strap rsp_reset_strap_props u_props (.*);

//--- testbench/test_rsp_reset_strap.sv
// self-checking bench for the reset strap block
`timescale 1ns/1ps
module test_rsp_reset_strap;
  reg clk, sys_rst, device_reset_low, want, sda_out_req, sda_oe_req, spi_read_active;
  reg autoconfig_sel_bit0, autoconfig_sel_bit1, autoconfig_sel_bit2, spi_read_data;
  reg pll_lock_indicator;
  reg [1:0] ref_source_select, mode;
  wire factory_strap_lock_pin_out, factory_strap_lock_pin_oe, ifmode1_readout_pin_out;
  wire ifmode1_readout_pin_oe, sda_pin_out, sda_pin_oe, xtal_driver_en, ext_clk_en;
  wire core_reset_q, spi_mode_q, serial_chip_select_low, ifmode0_chipsel_pin_in, miso_pin;
  wire [2:0] config_sel_q;
  wire [6:0] i2c_addr_q;
  wire [5:0] strap_capture_status_q;
  wire factory_strap_lock_pin_in = factory_strap_lock_pin_oe & factory_strap_lock_pin_out;
  wire ifmode1_readout_pin_in = ifmode1_readout_pin_oe ? ifmode1_readout_pin_out : miso_pin;
  integer bad_count = 0, num_checks = 0, cyc = 0, i, v;
  rsp_reset_strap dut (.*);
  rsp_host_model host (.clk, .in_reset(core_reset_q), .mode, .want,
    .cs_pin(ifmode0_chipsel_pin_in), .miso_pin);
  always #50 clk = ~clk;
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    bad_count = bad_count + (cyc == 1000);
    if (cyc == 1000)
      complete_run;
  end
  task tick(input integer n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task chk(input [31:0] g, input [31:0] e);
    num_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task boot(input [2:0] ac, input [1:0] m);
    device_reset_low = 1'h0;
    {autoconfig_sel_bit2, autoconfig_sel_bit1, autoconfig_sel_bit0} = ac;
    mode = m;
    tick(12);
    chk({core_reset_q, strap_capture_status_q}, 64);
    device_reset_low = 1'h1;
    tick(4);
    v = $urandom;
    {autoconfig_sel_bit2, autoconfig_sel_bit1, autoconfig_sel_bit0} = ~ac;
    {pll_lock_indicator, spi_read_data, sda_oe_req, spi_read_active, want} = {v[1:0], 3'h7};
    sda_out_req = 1'h0;
    tick(3);
    chk(core_reset_q, 0);
    chk(strap_capture_status_q, {m, ac});
    chk({config_sel_q, spi_mode_q}, {ac, m == 3});
    if (m != 3)
      chk(i2c_addr_q, 116 + m);
    chk(sda_pin_out, 0);
    chk({factory_strap_lock_pin_oe, factory_strap_lock_pin_out}, 2 + v[1]);
    chk({ifmode1_readout_pin_oe, ifmode1_readout_pin_oe & ifmode1_readout_pin_out,
      sda_pin_oe, serial_chip_select_low}, m == 3 ? 8 + 4 * v[0] : 3);
    $display("boot %h %h done", ac, m);
  endtask
  initial
  begin
    {clk, sys_rst, device_reset_low, want, sda_out_req, sda_oe_req, spi_read_active} = 7'h20;
    {autoconfig_sel_bit0, autoconfig_sel_bit1, autoconfig_sel_bit2, spi_read_data} = 4'h0;
    {pll_lock_indicator, ref_source_select, mode} = 5'h0;
    v = $urandom(32'h31c4bbaf);
    tick(2);
    sys_rst = 1'h0;
    for (i = 0; i < 6; i++)
    begin
      v = $urandom;
      boot(v[2:0], i[1:0]);
    end
    for (i = 0; i < 4; i++)
    begin
      ref_source_select = i[1:0];
      tick(2);
      chk({xtal_driver_en, ext_clk_en}, {i == 1, i == 2});
    end
    $display("ref select done");
    complete_run;
  end
endmodule // test_rsp_reset_strap
